/* File: rtl/amp_irq_pkg.sv */
package amp_irq_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_EVENT_MASK_LOW = 8'h20;
  localparam logic [7:0] ADDR_EVENT_MASK_HIGH = 8'h21;
  localparam logic [7:0] ADDR_LIVE_LOW = 8'h22;
  localparam logic [7:0] ADDR_LIVE_HIGH = 8'h23;
  localparam logic [7:0] ADDR_LATCH_LOW = 8'h24;
  localparam logic [7:0] ADDR_LATCH_HIGH = 8'h25;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_MASK_LOW = 8'hFC;
  localparam logic [7:0] RST_MASK_HIGH = 8'hB1;

  // ----------------------------------------
  // event bit positions (16-bit event vector)
  // ----------------------------------------
  localparam int EV_OVER_TEMP = 0;
  localparam int EV_OVER_CURRENT = 1;
  localparam int EV_TDM_CLK_ERR = 2;
  localparam int EV_LIM_ACTIVE = 3;
  localparam int EV_LIM_INFLECT = 4;
  localparam int EV_LIM_MAX_ATTEN = 5;
  localparam int EV_LIM_INF_HOLD = 6;
  localparam int EV_LIM_MUTE = 7;
  localparam int EV_PDM_CLK_ERR = 8;
  localparam int EV_BROWN_OUT = 9;
  localparam int EV_UNDERVOLT = 10;
  localparam int EV_OVERVOLT = 11;
  localparam int EV_PDM_DATA_INV = 15;

  // implemented event sources; bits 14..12 never raise
  localparam logic [15:0] EV_IMPL = 16'h8FFF;

  // ----------------------------------------
  // register access carrier
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

/* File: rtl/event_latch.sv */
`timescale 1ns/10ps
module event_latch (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [15:0] raw_event,
  input wire logic [15:0] clear_bits,
  output logic [15:0] live_ff,
  output logic [15:0] latch_ff
);

  // ----------------------------------------
  // two-stage sync then sticky latch per bit
  // ----------------------------------------
  logic [15:0] sync1_ff;

  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
        if (rst || !amp_irq_pkg::EV_IMPL[i]) begin
          sync1_ff[i] <= 1'b0;
          live_ff[i] <= 1'b0;
        end else begin
          sync1_ff[i] <= raw_event[i];
          live_ff[i] <= sync1_ff[i];
        end
      end

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          latch_ff[i] <= 1'b0;
        end else if (live_ff[i]) begin
          latch_ff[i] <= 1'b1;
        end else if (clear_bits[i]) begin
          latch_ff[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

/* File: rtl/amp_interrupt_mask_unit.sv */
`timescale 1ns/10ps
module amp_interrupt_mask_unit (
  input wire logic clk_sys,
  input wire logic rst,
  input amp_irq_pkg::reg_req_t req,
  input wire logic [15:0] raw_event,
  output logic [7:0] rdata_ff,
  output logic irq_ff
);

  // ----------------------------------------
  // internal state
  // ----------------------------------------
  logic [7:0] event_mask_low_ff;
  logic [7:0] event_mask_high_ff;
  logic [7:0] nxt_event_mask_low;
  logic [7:0] nxt_event_mask_high;
  logic [15:0] live_ff;
  logic [15:0] latch_ff;
  logic [15:0] clear_bits;
  logic [15:0] mask_vec;
  logic [15:0] pending;
  logic nxt_irq;
  logic [7:0] nxt_rdata;

  // ----------------------------------------
  // access decode
  // ----------------------------------------
  logic wr_mask_low;
  logic wr_mask_high;
  logic rd_latch_low;
  logic rd_latch_high;

  // writes to read-only or unmapped offsets decode to nothing
  assign wr_mask_low = req.wr &&
                       (req.addr == amp_irq_pkg::ADDR_EVENT_MASK_LOW);
  assign wr_mask_high = req.wr &&
                        (req.addr == amp_irq_pkg::ADDR_EVENT_MASK_HIGH);
  assign rd_latch_low = req.rd &&
                        (req.addr == amp_irq_pkg::ADDR_LATCH_LOW);
  assign rd_latch_high = req.rd &&
                         (req.addr == amp_irq_pkg::ADDR_LATCH_HIGH);

  // ----------------------------------------
  // readback words
  // ----------------------------------------
  logic [7:0] live_low;
  logic [7:0] live_high;
  logic [7:0] latch_low;
  logic [7:0] latch_high;

  assign live_low = live_ff[7:0];
  assign live_high = live_ff[15:8];
  assign latch_low = latch_ff[7:0];
  assign latch_high = latch_ff[15:8];

  // ----------------------------------------
  // low mask register
  // ----------------------------------------
  always_comb begin
    nxt_event_mask_low = event_mask_low_ff;
    if (wr_mask_low) begin
      nxt_event_mask_low = req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      event_mask_low_ff <= amp_irq_pkg::RST_MASK_LOW;
    end else begin
      event_mask_low_ff <= nxt_event_mask_low;
    end
  end

  // ----------------------------------------
  // high mask register
  // ----------------------------------------
  // every bit writable, reserved ones included
  always_comb begin
    nxt_event_mask_high = event_mask_high_ff;
    if (wr_mask_high) begin
      nxt_event_mask_high = req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      event_mask_high_ff <= amp_irq_pkg::RST_MASK_HIGH;
    end else begin
      event_mask_high_ff <= nxt_event_mask_high;
    end
  end

  // ----------------------------------------
  // read-to-clear strobes
  // ----------------------------------------
  // a still-present event wins over the clear
  always_comb begin
    clear_bits = 16'h0000;
    if (rd_latch_low) begin
      clear_bits[7:0] = 8'hFF;
    end
    if (rd_latch_high) begin
      clear_bits[15:8] = 8'hFF;
    end
  end

  // ----------------------------------------
  // event synchroniser and latches
  // ----------------------------------------
  event_latch event_latch_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .raw_event(raw_event),
    .clear_bits(clear_bits),
    .live_ff(live_ff),
    .latch_ff(latch_ff)
  );

  // ----------------------------------------
  // per-event mask vector
  // ----------------------------------------
  // high mask bit 7 gates event 15; bits 6..4 gate nothing
  genvar m;
  generate
    for (m = 0; m < 16; m++) begin : g_mask
      if (m < 8) begin : g_low
        assign mask_vec[m] = event_mask_low_ff[m];
      end else if (m == amp_irq_pkg::EV_PDM_DATA_INV) begin : g_data
        assign mask_vec[m] = event_mask_high_ff[7];
      end else if (amp_irq_pkg::EV_IMPL[m]) begin : g_high
        assign mask_vec[m] = event_mask_high_ff[m-8];
      end else begin : g_rsvd
        assign mask_vec[m] = 1'b1;
      end
    end
  endgenerate

  // ----------------------------------------
  // pending flags
  // ----------------------------------------
  // latched and unmasked
  genvar p;
  generate
    for (p = 0; p < 16; p++) begin : g_pend
      assign pending[p] = latch_ff[p] & ~mask_vec[p];
    end
  endgenerate

  // ----------------------------------------
  // interrupt output
  // ----------------------------------------
  // level, held while any flag pends
  always_comb begin
    nxt_irq = |pending;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // ----------------------------------------
  // read data select
  // ----------------------------------------
  // holds between reads
  always_comb begin
    nxt_rdata = rdata_ff;
    if (req.rd) begin
      case (req.addr)
        amp_irq_pkg::ADDR_EVENT_MASK_LOW: begin
          nxt_rdata = event_mask_low_ff;
        end
        amp_irq_pkg::ADDR_EVENT_MASK_HIGH: begin
          nxt_rdata = event_mask_high_ff;
        end
        amp_irq_pkg::ADDR_LIVE_LOW: begin
          nxt_rdata = live_low;
        end
        amp_irq_pkg::ADDR_LIVE_HIGH: begin
          nxt_rdata = live_high;
        end
        amp_irq_pkg::ADDR_LATCH_LOW: begin
          nxt_rdata = latch_low;
        end
        amp_irq_pkg::ADDR_LATCH_HIGH: begin
          nxt_rdata = latch_high;
        end
        default: begin
          nxt_rdata = 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------
  // read data register
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

endmodule

/* File: dv/amp_interrupt_mask_unit_asserts.sv */
`timescale 1ns/10ps
module amp_irq_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input amp_irq_pkg::reg_req_t req,
  input wire logic [15:0] raw_event,
  input wire logic [7:0] rdata_ff,
  input wire logic irq_ff
);
  logic wr_ff;
  logic odd_ff;
  always_ff @(posedge clk_sys) wr_ff <= !rst && (wr_ff || req.wr);
  always_ff @(posedge clk_sys)
    odd_ff <= !rst && (odd_ff || req.wr || (|(raw_event & ~16'h81FC)));
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ----
  // checks
  // ----
  rst_quiet_a: assert property ($past(rst) |-> rdata_ff == 8'h00 && !irq_ff)
    else $error("outputs not idle after reset");
  low_rst_a: assert property
    (req.rd && req.addr == 8'h20 && !wr_ff |=> rdata_ff == 8'hFC)
    else $error("low mask reset wrong");
  high_rst_a: assert property
    (req.rd && req.addr == 8'h21 && !wr_ff |=> rdata_ff == 8'hB1)
    else $error("high mask reset wrong");
  dflt_mask_a: assert property (!odd_ff |-> !irq_ff)
    else $error("default masked source raised irq");
  over_temp_a: assert property (raw_event[0] [*6] ##0 !wr_ff |-> irq_ff)
    else $error("over temperature not reported");
  over_curr_a: assert property (raw_event[1] [*6] ##0 !wr_ff |-> irq_ff)
    else $error("over current not reported");
  live_read_a: assert property (($stable(raw_event)) [*4] ##0
    (req.rd && req.addr == 8'h22) |=> rdata_ff == $past(raw_event[7:0]))
    else $error("live readback wrong");
  read_clear_a: assert property ((raw_event == 16'h0) [*4] ##0
    (req.rd && req.addr == 8'h24) ##1 (req.rd && req.addr == 8'h24)
    |=> rdata_ff == 8'h00) else $error("latch not cleared by read");
endmodule
bind amp_interrupt_mask_unit amp_irq_checker amp_irq_checker_inst (
  .clk_sys, .rst, .req, .raw_event, .rdata_ff, .irq_ff);

/* File: dv/amp_interrupt_mask_unit_test.sv */
`timescale 1ns/10ps
module amp_interrupt_mask_unit_test;
  logic clk_sys = 0;
  logic rst = 1;
  amp_irq_pkg::reg_req_t req = '0;
  logic [15:0] raw_event = '0;
  logic [7:0] rdata_ff;
  logic irq_ff;
  logic due = 0;
  logic [7:0] acc;
  logic [7:0] exp_q[$];
  int fails = 0;
  int checks = 0;
  amp_interrupt_mask_unit amp_interrupt_mask_unit_inst (
    .clk_sys, .rst, .req, .raw_event, .rdata_ff, .irq_ff);
  initial forever #12.5 clk_sys = ~clk_sys;
  // ----
  // tasks
  // ----
  task automatic check(string n, logic [7:0] s, logic [7:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    if (!w) exp_q.push_back(d);
    @(negedge clk_sys);
  endtask
  task automatic idle(int n);
    req = '0;
    repeat (n) @(negedge clk_sys);
  endtask
  always @(posedge clk_sys) due <= req.rd;
  always @(negedge clk_sys) if (due) check("rdata", rdata_ff, exp_q.pop_front());
  initial begin
    #5000;
    fails++;
    conclude();
  end
  initial begin
    void'($urandom(32'h4448));
    idle(3);
    rst = 0;
    bus(0, 8'h20, 8'hFC);
    bus(0, 8'h21, 8'hB1);
    raw_event = 16'h81FC;
    acc = raw_event[7:0];
    idle(8);
    check("irq", {7'h0, irq_ff}, 8'h00);
    $display("test defaults done");
    for (int b = 0; b < 2; b++) begin
      raw_event = 16'h1 << b;
      idle(7);
      check("irq", {7'h0, irq_ff}, 8'h01);
      raw_event = '0;
      idle(4);
      bus(0, 8'h24, acc | (8'h1 << b));
      bus(0, 8'h24, 8'h00);
      acc = '0;
      idle(3);
      check("irq", {7'h0, irq_ff}, 8'h00);
    end
    $display("test latch done");
    bus(1, 8'h20, 8'hFF);
    bus(1, 8'h21, 8'hFF);
    raw_event = 16'($urandom) | 16'h0080;
    idle(6);
    check("irq", {7'h0, irq_ff}, 8'h00);
    bus(0, 8'h22, raw_event[7:0]);
    bus(1, 8'h22, 8'h00);
    bus(1, 8'h20, 8'h7F);
    bus(0, 8'h20, 8'h7F);
    bus(0, 8'h22, raw_event[7:0]);
    bus(0, 8'h24, raw_event[7:0]);
    bus(0, 8'h24, raw_event[7:0]);
    idle(3);
    check("irq", {7'h0, irq_ff}, 8'h01);
    $display("test masks done");
    bus(1, 8'h20, 8'hFF);
    bus(1, 8'h21, 8'h7F);
    idle(3);
    check("irq", {7'h0, irq_ff}, 8'h01);
    bus(1, 8'h21, 8'hFE);
    bus(0, 8'h21, 8'hFE);
    idle(3);
    check("irq", {7'h0, irq_ff}, 8'h01);
    bus(1, 8'h21, 8'h8F);
    bus(0, 8'h21, 8'h8F);
    idle(3);
    check("irq", {7'h0, irq_ff}, 8'h00);
    $display("test high mask done");
    conclude();
  end
endmodule
